// >>> input_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a vector of pin levels
module input_sync #(
	parameter int unsigned width = 8
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic [width-1:0] async_in,
	output var  logic [width-1:0] sync_out
);
	logic [width-1:0] stage1_q;

	// first stage feeds only the second
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1_q <= '0;
			sync_out <= '0;
		end else begin
			stage1_q <= async_in;
			sync_out <= stage1_q;
		end
	end
endmodule // input_sync
`default_nettype wire

// >>> pca_port_pin_routing.sv
// Summary of operation
// RQ1: routing register at address 0xa4, page 2 only, resets to zero.
// RQ2: bit 7 picks channel 4 capture: own pin or comparator output.
// RQ3: bit 6 picks channel 2 capture: own pin or low-speed oscillator.
// RQ4: bit 5 puts channel 2 clones on P4.0/P4.1 or P3.4/P3.5.
// RQ5: bit 4 puts channel 0 clones on P2.0/P2.1 or P6.0/P6.1.
// RQ6: bit 3 puts channels 3 and 5 on P3.4/P3.5 or P2.0/P2.1.
// RQ7: bit 2 puts channels 0,2,4 on P2.2/P2.4/P2.6 or P3.0/P3.1/P3.3.
// RQ8: channel 1 owns P3.3; channel 4 then belongs on P2.6. Code keeps channel 4 on P3.3 under bit 2; channel_oe[1] overrides it.
// RQ9: bit 1 takes the external count input from P1.3 or P1.6.
// RQ10: bit 0 drives counter clock output to P4.7 or P3.3.
// RQ11: clock output runs only when enabled, toggling per two base overflows.
// RQ12: routing follows the register directly; unselected inputs have no effect.
`timescale 1ns/1ps
`default_nettype none
module pca_port_pin_routing (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// special function register bus
	input  wire logic [7:0] sfr_addr,
	input  wire logic [3:0] sfr_page,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_rsel,
	// counter array channel outputs and their output enables
	input  wire logic [5:0] channel_out,
	input  wire logic [5:0] channel_oe,
	input  wire logic       ch0_clone_a,
	input  wire logic       ch0_clone_b,
	input  wire logic       ch0_clone_a_oe,
	input  wire logic       ch0_clone_b_oe,
	input  wire logic       ch2_clone_a,
	input  wire logic       ch2_clone_b,
	input  wire logic       ch2_clone_a_oe,
	input  wire logic       ch2_clone_b_oe,
	input  wire logic       base_overflow,
	input  wire logic       counter_clock_out_enable,
	// sources for capture inputs
	input  wire logic       comparator_output,
	input  wire logic       internal_low_speed_osc,
	// port pins (8 bits each)
	input  wire logic [7:0] p1_in,
	input  wire logic [7:0] p2_in,
	input  wire logic [7:0] p3_in,
	output logic      [7:0] p2_out,
	output logic      [7:0] p2_oe,
	output logic      [7:0] p3_out,
	output logic      [7:0] p3_oe,
	output logic      [7:0] p4_out,
	output logic      [7:0] p4_oe,
	output logic      [7:0] p6_out,
	output logic      [7:0] p6_oe,
	// inputs delivered to the counter array
	output logic      [5:0] channel_capture_in,
	output logic            external_count_input,
	output logic            counter_clock_out
);
	logic [7:0] route_q;
	logic [7:0] route_d;
	logic [7:0] p1_s;
	logic [7:0] p2_s;
	logic [7:0] p3_s;
	logic [1:0] async_s;
	logic       clk_out_q;
	logic       clk_out_d;
	logic       half_q;
	logic       half_d;
	pin_route_pkg::clk_out_state_t clk_state_q;
	pin_route_pkg::clk_out_state_t clk_state_d;

	// pins and unrelated-clock sources cross into core_clk
	input_sync #(.width(24)) u_pin_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({p1_in, p2_in, p3_in}),
		.sync_out ({p1_s, p2_s, p3_s})
	);
	// channel enables are core_clk logic and need no synchroniser
	input_sync #(.width(2)) u_src_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({comparator_output, internal_low_speed_osc}),
		.sync_out (async_s)
	);

	// RQ1: address decode
	wire hit = (sfr_addr == pin_route_pkg::route_addr) && (sfr_page == pin_route_pkg::route_page);
	assign route_d = (hit && sfr_wr) ? sfr_wdata : route_q;
	assign sfr_rsel = hit;
	assign sfr_rdata = hit ? route_q : 8'h00;

	// RQ1: routing register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			route_q <= pin_route_pkg::route_reset;
		end else begin
			route_q <= route_d;
		end
	end

	// selector bits
	wire sel_c4 = route_q[pin_route_pkg::ch4_capture_source_sel];
	wire sel_c2 = route_q[pin_route_pkg::ch2_capture_source_sel];
	wire sel_cl2 = route_q[pin_route_pkg::ch2_clone_pin_sel];
	wire sel_cl0 = route_q[pin_route_pkg::ch0_clone_pin_sel];
	wire sel_35 = route_q[pin_route_pkg::ch3_ch5_pin_sel];
	wire sel_024 = route_q[pin_route_pkg::ch0_ch2_ch4_pin_sel];
	wire sel_eci = route_q[pin_route_pkg::ext_count_input_pin_sel];
	wire sel_cko = route_q[pin_route_pkg::counter_clock_out_pin_sel];

	// RQ12: capture inputs come only from the selected pin or source
	wire ch0_pin = sel_024 ? p3_s[pin_route_pkg::pin0] : p2_s[pin_route_pkg::pin2];
	wire ch2_pin = sel_024 ? p3_s[pin_route_pkg::pin1] : p2_s[pin_route_pkg::pin4];
	wire ch4_pin = sel_024 ? p3_s[pin_route_pkg::pin3] : p2_s[pin_route_pkg::pin6];
	wire ch3_pin = sel_35 ? p2_s[pin_route_pkg::pin0] : p3_s[pin_route_pkg::pin4];
	wire ch5_pin = sel_35 ? p2_s[pin_route_pkg::pin1] : p3_s[pin_route_pkg::pin5];
	// channel 1 capture is fixed on P3.3
	wire ch1_pin = p3_s[pin_route_pkg::pin3];
	// RQ2: channel 4 capture source
	wire ch4_cap = sel_c4 ? async_s[1] : ch4_pin;
	// RQ3: channel 2 capture source
	wire ch2_cap = sel_c2 ? async_s[0] : ch2_pin;
	assign channel_capture_in = {ch5_pin, ch4_cap, ch3_pin, ch2_cap, ch1_pin, ch0_pin};
	// RQ9: external count input pin
	assign external_count_input = sel_eci ? p1_s[pin_route_pkg::pin6] : p1_s[pin_route_pkg::pin3];

	// RQ11: divider state, runs only while enabled
	assign clk_state_d = counter_clock_out_enable ? pin_route_pkg::clk_out_run : pin_route_pkg::clk_out_idle;
	always_comb begin
		half_d = half_q;
		clk_out_d = clk_out_q;
		case (clk_state_q)
			pin_route_pkg::clk_out_idle: begin
				half_d = 1'b0;
				clk_out_d = 1'b0;
			end
			pin_route_pkg::clk_out_run: begin
				// RQ11: enable drop clears divider at once
				if (!counter_clock_out_enable) begin
					half_d = 1'b0;
					clk_out_d = 1'b0;
				end else if (base_overflow) begin
					// toggle on every second overflow
					half_d = ~half_q;
					if (half_q) begin
						clk_out_d = ~clk_out_q;
					end
				end
			end
			default: begin
				half_d = 1'b0;
				clk_out_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			clk_state_q <= pin_route_pkg::clk_out_idle;
			half_q <= 1'b0;
			clk_out_q <= 1'b0;
		end else begin
			clk_state_q <= clk_state_d;
			half_q <= half_d;
			clk_out_q <= clk_out_d;
		end
	end
	assign counter_clock_out = clk_out_q;
	wire cko_on = counter_clock_out_enable;

	// output pin drive per routing selection
	always_comb begin
		p2_out = 8'h00;
		p2_oe = 8'h00;
		p3_out = 8'h00;
		p3_oe = 8'h00;
		p4_out = 8'h00;
		p4_oe = 8'h00;
		p6_out = 8'h00;
		p6_oe = 8'h00;
		// RQ7: channels 0, 2, 4 main pins
		if (sel_024) begin
			p3_out[pin_route_pkg::pin0] = channel_out[0];
			p3_oe[pin_route_pkg::pin0] = channel_oe[0];
			p3_out[pin_route_pkg::pin1] = channel_out[2];
			p3_oe[pin_route_pkg::pin1] = channel_oe[2];
			p3_out[pin_route_pkg::pin3] = channel_out[4];
			p3_oe[pin_route_pkg::pin3] = channel_oe[4];
		end else begin
			p2_out[pin_route_pkg::pin2] = channel_out[0];
			p2_oe[pin_route_pkg::pin2] = channel_oe[0];
			p2_out[pin_route_pkg::pin4] = channel_out[2];
			p2_oe[pin_route_pkg::pin4] = channel_oe[2];
			p2_out[pin_route_pkg::pin6] = channel_out[4];
			p2_oe[pin_route_pkg::pin6] = channel_oe[4];
		end
		// RQ6: channels 3 and 5
		if (sel_35) begin
			p2_out[pin_route_pkg::pin0] = channel_out[3];
			p2_oe[pin_route_pkg::pin0] = channel_oe[3];
			p2_out[pin_route_pkg::pin1] = channel_out[5];
			p2_oe[pin_route_pkg::pin1] = channel_oe[5];
		end else begin
			p3_out[pin_route_pkg::pin4] = channel_out[3];
			p3_oe[pin_route_pkg::pin4] = channel_oe[3];
			p3_out[pin_route_pkg::pin5] = channel_out[5];
			p3_oe[pin_route_pkg::pin5] = channel_oe[5];
		end
		// RQ5: channel 0 clones
		if (sel_cl0) begin
			p6_out[pin_route_pkg::pin0] = ch0_clone_a;
			p6_oe[pin_route_pkg::pin0] = ch0_clone_a_oe;
			p6_out[pin_route_pkg::pin1] = ch0_clone_b;
			p6_oe[pin_route_pkg::pin1] = ch0_clone_b_oe;
		end else begin
			if (ch0_clone_a_oe) begin
				p2_out[pin_route_pkg::pin0] = ch0_clone_a;
				p2_oe[pin_route_pkg::pin0] = 1'b1;
			end
			if (ch0_clone_b_oe) begin
				p2_out[pin_route_pkg::pin1] = ch0_clone_b;
				p2_oe[pin_route_pkg::pin1] = 1'b1;
			end
		end
		// RQ4: channel 2 clones
		if (sel_cl2) begin
			if (ch2_clone_a_oe) begin
				p3_out[pin_route_pkg::pin4] = ch2_clone_a;
				p3_oe[pin_route_pkg::pin4] = 1'b1;
			end
			if (ch2_clone_b_oe) begin
				p3_out[pin_route_pkg::pin5] = ch2_clone_b;
				p3_oe[pin_route_pkg::pin5] = 1'b1;
			end
		end else begin
			p4_out[pin_route_pkg::pin0] = ch2_clone_a;
			p4_oe[pin_route_pkg::pin0] = ch2_clone_a_oe;
			p4_out[pin_route_pkg::pin1] = ch2_clone_b;
			p4_oe[pin_route_pkg::pin1] = ch2_clone_b_oe;
		end
		// RQ10: clock output pin
		if (sel_cko) begin
			if (cko_on) begin
				p3_out[pin_route_pkg::pin3] = clk_out_q;
				p3_oe[pin_route_pkg::pin3] = 1'b1;
			end
		end else begin
			p4_out[pin_route_pkg::pin7] = clk_out_q;
			p4_oe[pin_route_pkg::pin7] = cko_on;
		end
		// RQ8: channel 1 takes P3.3 over channel 4
		if (channel_oe[1]) begin
			p3_out[pin_route_pkg::pin3] = channel_out[1];
			p3_oe[pin_route_pkg::pin3] = 1'b1;
		end
	end
endmodule // pca_port_pin_routing
`default_nettype wire

// >>> pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// port pins and analog sources outside the block
module pin_partner (
	input  wire logic [7:0] pat,
	output logic      [7:0] p1_in,
	output logic      [7:0] p2_in,
	output logic      [7:0] p3_in,
	output logic            comparator_output,
	output logic            internal_low_speed_osc
);
	// every port shows one level pattern
	assign p1_in = pat;
	assign p2_in = pat;
	assign p3_in = pat;
	assign comparator_output = pat[0];
	assign internal_low_speed_osc = pat[1];
endmodule // pin_partner
`default_nettype wire

// >>> pin_route_pkg.sv
package pin_route_pkg;
	// special function register location of the routing register
	localparam logic [7:0] route_addr = 8'ha4;
	localparam logic [3:0] route_page = 4'h2;
	localparam logic [7:0] route_reset = 8'h00;
	// field positions
	localparam int unsigned ch4_capture_source_sel = 7;
	localparam int unsigned ch2_capture_source_sel = 6;
	localparam int unsigned ch2_clone_pin_sel = 5;
	localparam int unsigned ch0_clone_pin_sel = 4;
	localparam int unsigned ch3_ch5_pin_sel = 3;
	localparam int unsigned ch0_ch2_ch4_pin_sel = 2;
	localparam int unsigned ext_count_input_pin_sel = 1;
	localparam int unsigned counter_clock_out_pin_sel = 0;
	// port pin indices within the 8-bit pin vectors
	localparam int unsigned pin0 = 0;
	localparam int unsigned pin1 = 1;
	localparam int unsigned pin2 = 2;
	localparam int unsigned pin3 = 3;
	localparam int unsigned pin4 = 4;
	localparam int unsigned pin5 = 5;
	localparam int unsigned pin6 = 6;
	localparam int unsigned pin7 = 7;
	// states of the clock output divider
	typedef enum logic [0:0] {
		clk_out_idle = 1'b0,
		clk_out_run  = 1'b1
	} clk_out_state_t;
endpackage

// >>> pin_route_props.sv
`timescale 1ns/1ps
`default_nettype none
// routing checks against a shadow of the route register
module pin_route_props (
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic [7:0] sfr_addr,
	input wire logic [3:0] sfr_page,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_rsel,
	input wire logic [5:0] channel_oe,
	input wire logic       counter_clock_out_enable,
	input wire logic [7:0] p1_in,
	input wire logic [7:0] p2_oe,
	input wire logic [7:0] p3_oe,
	input wire logic [7:0] p4_oe,
	input wire logic       external_count_input,
	input wire logic       counter_clock_out
);
	wire logic  hit = sfr_addr == 8'ha4 && sfr_page == 4'h2;
	logic [7:0] shadow_q;
	logic [1:0] warm_q;
	// shadow of the register, settle count for the synchronisers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shadow_q <= 8'h00;
			warm_q <= 2'h0;
		end else begin
			if (sfr_wr && hit) shadow_q <= sfr_wdata;
			if (warm_q != 2'h3) warm_q <= warm_q + 2'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence hit_write;
		sfr_wr && hit ##1 hit;
	endsequence
	a_decode_hit: assert property (sfr_rsel == hit) else $error("select mismatch");
	a_read_value: assert property (sfr_rdata == (hit ? shadow_q : 8'h00)) else $error("read mismatch");
	a_write_lands: assert property (hit_write |-> sfr_rdata == $past(sfr_wdata)) else $error("write lost");
	a_ch0_pin: assert property (shadow_q[2] ? p3_oe[0] == channel_oe[0] && !p2_oe[2] : p2_oe[2] == channel_oe[0])
		else $error("channel 0 pin mismatch");
	a_ch1_owns_pin: assert property (channel_oe[1] |-> p3_oe[3]) else $error("channel 1 pin lost");
	a_count_in_route: assert property (warm_q == 2'h3 |-> external_count_input ==
		(shadow_q[1] ? $past(p1_in[6], 2) : $past(p1_in[3], 2))) else $error("count input mismatch");
	a_clk_out_pin: assert property (counter_clock_out_enable |-> p4_oe[7] == !shadow_q[0])
		else $error("clock out pin mismatch");
	a_clk_out_stop: assert property (!counter_clock_out_enable |=> !counter_clock_out) else $error("clock runs");
endmodule // pin_route_props
`default_nettype wire

// >>> tb_pca_port_pin_routing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pca_port_pin_routing;
	logic       core_clk, nrst, sfr_wr, sfr_rsel, base_overflow, counter_clock_out_enable;
	logic       ch0_clone_a, ch0_clone_b, ch0_clone_a_oe, ch0_clone_b_oe, comparator_output;
	logic       ch2_clone_a, ch2_clone_b, ch2_clone_a_oe, ch2_clone_b_oe, internal_low_speed_osc;
	logic       external_count_input, counter_clock_out;
	logic [3:0] sfr_page;
	logic [5:0] channel_out, channel_oe, channel_capture_in;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pat, d, p1_in, p2_in, p3_in;
	logic [7:0] p2_out, p2_oe, p3_out, p3_oe, p4_out, p4_oe, p6_out, p6_oe;
	logic [7:0] tbl [4] = '{8'h00, 8'h14, 8'h39, 8'h22};
	int         err_count, compares;
	pca_port_pin_routing u_pca_port_pin_routing (.core_clk, .nrst, .sfr_addr, .sfr_page, .sfr_wr,
		.sfr_wdata, .sfr_rdata, .sfr_rsel, .channel_out, .channel_oe, .ch0_clone_a, .ch0_clone_b,
		.ch0_clone_a_oe, .ch0_clone_b_oe, .ch2_clone_a, .ch2_clone_b, .ch2_clone_a_oe, .ch2_clone_b_oe,
		.base_overflow, .counter_clock_out_enable, .comparator_output, .internal_low_speed_osc, .p1_in,
		.p2_in, .p3_in, .p2_out, .p2_oe, .p3_out, .p3_oe, .p4_out, .p4_oe, .p6_out, .p6_oe,
		.channel_capture_in, .external_count_input, .counter_clock_out);
	pin_partner u_pin_partner (.pat, .p1_in, .p2_in, .p3_in, .comparator_output, .internal_low_speed_osc);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] e);
		compares++;
		if (got !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, got);
		end
	endtask
	// register write, strobe dropped after its edge
	task automatic wr(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] v);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_page <= pg;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [3:0] pg, input logic [7:0] e);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_page <= pg;
		@(negedge core_clk);
		chk("route read", sfr_rdata, e);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{nrst, sfr_wr, base_overflow, sfr_addr, sfr_page, sfr_wdata, pat} = 31'h0;
		{ch0_clone_a, ch0_clone_b, ch2_clone_a, ch2_clone_b} = 4'b1001;
		{ch0_clone_a_oe, ch0_clone_b_oe, ch2_clone_a_oe, ch2_clone_b_oe, counter_clock_out_enable} = 5'h1f;
		channel_out = 6'h19;
		channel_oe = 6'h3d;
		err_count = 0;
		compares = 0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		rd(8'ha4, 4'h2, 8'h00);
		wr(8'ha4, 4'h4, 8'hff);
		wr(8'ha5, 4'h2, 8'hff);
		rd(8'ha4, 4'h4, 8'h00);
		rd(8'ha4, 4'h2, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(8'ha4, 4'h2, 8'h01 << i);
			rd(8'ha4, 4'h2, 8'h01 << i);
		end
		foreach (tbl[k]) begin
			d = tbl[k];
			wr(8'ha4, 4'h2, d);
			chk("ch0 pins", {5'h0, p2_oe[2], p3_oe[0], p2_out[2] | p3_out[0]}, d[2] ? 8'h03 : 8'h05);
			chk("ch0 clones", {2'h0, p6_oe[1:0], d[4] ? {p6_out[1:0], p6_oe[1:0]} : {p2_out[1:0], p2_oe[1:0]}},
				{2'h0, d[4] ? 2'h3 : 2'h0, 4'h7});
			chk("ch2 clones", {2'h0, p4_oe[1:0], d[5] ? {p3_out[5:4], p3_oe[5:4]} : {p4_out[1:0], p4_oe[1:0]}},
				{2'h0, d[5] ? 2'h0 : 2'h3, 4'hb});
			if (d[3] ? d[4] : !d[5]) chk("ch3 ch5 pins", {4'h0, d[3] ? {p2_out[1:0], p2_oe[1:0]} :
				{p3_out[5:4], p3_oe[5:4]}}, 8'h07);
			chk("clock out pin", {6'h0, p4_oe[7], p3_oe[3]}, {6'h0, !d[0], d[0] | d[2]});
		end
		for (int j = 0; j < 8; j++) begin
			@(posedge core_clk);
			pat <= j[0] ? 8'h50 : 8'h0b;
			d = j[1] ? 8'hc2 : 8'h00;
			d[3:2] = {2{j[2]}};
			wr(8'ha4, 4'h2, d);
			repeat (3) @(negedge core_clk);
			chk("routed inputs", {5'h0, external_count_input, channel_capture_in[4], channel_capture_in[2]},
				{5'h0, d[1] ? pat[6] : pat[3], d[7] ? pat[0] : d[2] ? pat[3] : pat[6], d[6] | d[2] ? pat[1] : pat[4]});
			chk("capture pins", {4'h0, channel_capture_in[5], channel_capture_in[3], channel_capture_in[1],
				channel_capture_in[0]}, {4'h0, d[3] ? pat[1] : pat[5], d[3] ? pat[0] : pat[4], pat[3], d[2] ? pat[0] : pat[2]});
		end
		@(posedge core_clk);
		channel_oe <= 6'h3f;
		wr(8'ha4, 4'h2, 8'h05);
		chk("ch1 pin", {6'h0, p3_oe[3], p3_out[3]}, 8'h02);
		@(posedge core_clk);
		counter_clock_out_enable <= 1'b0;
		repeat (2) @(posedge core_clk);
		counter_clock_out_enable <= 1'b1;
		repeat (2) @(posedge core_clk);
		for (int i = 1; i <= 6; i++) begin
			base_overflow <= 1'b1;
			@(posedge core_clk);
			base_overflow <= 1'b0;
			repeat (2) @(negedge core_clk);
			chk("clock out", {7'h0, counter_clock_out}, {7'h0, i[1]});
			@(posedge core_clk);
		end
		counter_clock_out_enable <= 1'b0;
		wr(8'ha4, 4'h2, 8'h00);
		chk("clock out stop", {6'h0, counter_clock_out, p4_oe[7]}, 8'h00);
		tally_and_finish();
	end
endmodule // tb_pca_port_pin_routing
bind pca_port_pin_routing pin_route_props u_pin_route_props (.core_clk, .nrst, .sfr_addr, .sfr_page, .sfr_wr,
	.sfr_wdata, .sfr_rdata, .sfr_rsel, .channel_oe, .counter_clock_out_enable, .p1_in, .p2_oe, .p3_oe,
	.p4_oe, .external_count_input, .counter_clock_out);
`default_nettype wire
